// [hw/abc_pkg.sv]
// Package: constants and carrier types for the backplane bus controller
package abc_pkg;
  localparam int CLK_MHZ = 20;
  localparam int TIMEOUT_US = 10;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam int AD_W = 18;
  localparam int ADDR_HI_BIT = 17;
  localparam int ADDR_ERR_BIT = 16;
  localparam int EVENT_LEVEL = 6;
  localparam logic [2:0] LEVEL_NONE = 3'h0;

  // Bus control lines as seen by the controller, true means asserted (low on wire)
  typedef struct packed {
    logic cycle_sync;
    logic input_strobe;
    logic output_strobe;
    logic slave_reply;
    logic write_byte_control;
    logic io_page_select;
    logic dma_request_line;
    logic dma_select_ack;
    logic int_request_level_four;
    logic int_request_level_five;
    logic int_request_level_six;
    logic int_request_level_seven;
    logic external_event_request;
    logic halt_request_line;
    logic memory_refresh_line;
    logic ac_power_good;
    logic dc_power_good;
  } abc_ctl_type;

  // Master transaction request from the user side
  typedef struct packed {
    logic valid;
    logic write;
    logic byte_mode;
    logic io_page;
    logic [AD_W-1:0] addr;
    logic [15:0] wdata;
  } abc_req_type;

  // Transaction answer to the user side
  typedef struct packed {
    logic done;
    logic timeout;
    logic mem_error;
    logic [15:0] rdata;
  } abc_rsp_type;
endpackage

// [hw/abc_sync.sv]
// Two-stage synchroniser for a vector of bus control lines
`timescale 1ns/10ps
module abc_sync #(
  parameter int W = 17
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } abc_sync_st_type;
  abc_sync_st_type st_q;
  abc_sync_st_type st_d;

  // An empty vector has nothing to carry
  if (W < 1) begin : g_bad_width
    $error("W must be at least one");
  end

  // First stage read only by the second
  always_comb begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule

// [hw/abc_ctrl.sv]
// Bus controller: arbitration, interlocked master cycles, timeout, system lines
`timescale 1ns/10ps
module abc_ctrl #(
  parameter int TIMEOUT_CYCLES = abc_pkg::TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire abc_pkg::abc_req_type req,
  output abc_pkg::abc_rsp_type rsp,
  output logic req_ready,
  input wire logic [abc_pkg::AD_W-1:0] ad_in_n,
  output logic [abc_pkg::AD_W-1:0] ad_out,
  output logic [abc_pkg::AD_W-1:0] ad_oe,
  input wire abc_pkg::abc_ctl_type ctl_in_n,
  output abc_pkg::abc_ctl_type ctl_oe,
  output logic dma_grant_out_n,
  output logic int_ack_out_n,
  input wire logic int_ack_take,
  output logic bus_initialize_oe,
  output logic [2:0] irq_level,
  output logic irq_event,
  output logic console_debug_mode,
  output logic power_fail_trap
);
  // Counter is 16 bits wide; must outlast the slowest slave reply
  if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 65535) begin : g_bad_timeout
    $error("TIMEOUT_CYCLES out of range");
  end

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_ADDR = 6'h02,
    S_DATA = 6'h04,
    S_WAIT_REL = 6'h08,
    S_GRANT = 6'h10,
    S_DMA = 6'h20
  } abc_state_type;

  typedef struct packed {
    abc_state_type state;
    logic [15:0] tmr;
    abc_pkg::abc_req_type cur;
    abc_pkg::abc_rsp_type rsp;
    logic event_prev;
    logic event_pend;
    logic halted;
    logic pfail;
    logic pok_prev;
    logic init_done;
  } abc_st_type;

  abc_st_type st_q;
  abc_st_type st_d;
  abc_pkg::abc_ctl_type ctl_s;
  logic [abc_pkg::AD_W-1:0] ad_s;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronise received lines; wire is low-true so invert first
  abc_sync #(.W($bits(abc_pkg::abc_ctl_type))) u_sync_ctl (
    .clk(clk),
    .rst_n(rst_n),
    .d(~ctl_in_n),
    .q(ctl_s)
  );
  abc_sync #(.W(abc_pkg::AD_W)) u_sync_ad (
    .clk(clk),
    .rst_n(rst_n),
    .d(~ad_in_n),
    .q(ad_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    st_d = st_q;
    st_d.rsp.done = 1'b0;
    st_d.init_done = 1'b1;
    // Event edge latched; a new edge wins over the take
    st_d.event_prev = ctl_s.external_event_request;
    if (int_ack_take) begin
      st_d.event_pend = 1'b0;
    end
    if (ctl_s.external_event_request && !st_q.event_prev) begin
      st_d.event_pend = 1'b1;
    end
    st_d.halted = ctl_s.halt_request_line;
    st_d.pok_prev = ctl_s.ac_power_good;
    if (st_q.pok_prev && !ctl_s.ac_power_good && !st_q.halted) begin
      st_d.pfail = 1'b1;
    end
    case (st_q.state)
      S_IDLE: begin
        st_d.tmr = '0;
        // Grant only between cycles while not driving sync
        if (ctl_s.dma_request_line && !ctl_s.cycle_sync) begin
          st_d.state = S_GRANT;
        end else if (req.valid && !st_q.halted) begin
          st_d.cur = req;
          st_d.rsp.timeout = 1'b0;
          st_d.rsp.mem_error = 1'b0;
          st_d.state = S_ADDR;
        end
      end
      S_ADDR: begin
        st_d.state = S_DATA; // One cycle of address setup before sync
      end
      S_DATA: begin
        st_d.tmr = st_q.tmr + 16'h0001;
        if (ctl_s.slave_reply) begin
          if (!st_q.cur.write) begin
            st_d.rsp.rdata = ad_s[15:0];
            st_d.rsp.mem_error = ad_s[abc_pkg::ADDR_ERR_BIT];
          end
          st_d.tmr = '0;
          st_d.state = S_WAIT_REL;
        end else if (st_q.tmr == 16'(TIMEOUT_CYCLES - 1)) begin
          st_d.rsp.timeout = 1'b1;
          st_d.rsp.done = 1'b1;
          st_d.state = S_IDLE;
        end
      end
      S_WAIT_REL: begin
        // Strobe dropped; wait for reply release before ending sync
        if (!ctl_s.slave_reply) begin
          st_d.rsp.done = 1'b1;
          st_d.state = S_IDLE;
        end
      end
      S_GRANT: begin
        if (ctl_s.dma_select_ack) begin
          st_d.state = S_DMA;
        end else if (!ctl_s.dma_request_line) begin
          st_d.state = S_IDLE;
        end
      end
      S_DMA: begin
        if (!ctl_s.dma_select_ack) begin
          st_d.state = S_IDLE;
        end
      end
      default: begin
        st_d.state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.state <= S_IDLE;
      st_q.pok_prev <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus drive; enables only pull low, so value presented is zero
  logic mastering;
  logic data_phase;
  always_comb begin
    mastering = (st_q.state == S_ADDR) || (st_q.state == S_DATA) || (st_q.state == S_WAIT_REL);
    data_phase = (st_q.state == S_DATA);
    ctl_oe = '0;
    ad_out = '0;
    ad_oe = '0;
    if (mastering) begin
      ctl_oe.cycle_sync = (st_q.state != S_ADDR);
      ctl_oe.write_byte_control = (st_q.state == S_ADDR) ? st_q.cur.write : (data_phase && st_q.cur.byte_mode);
      ctl_oe.io_page_select = (st_q.state == S_ADDR) && st_q.cur.io_page && !ctl_s.memory_refresh_line;
      ctl_oe.input_strobe = data_phase && !st_q.cur.write;
      ctl_oe.output_strobe = data_phase && st_q.cur.write;
      if (st_q.state == S_ADDR) begin
        ad_oe = st_q.cur.addr;
      end else if (data_phase && st_q.cur.write) begin
        ad_oe = {2'h0, st_q.cur.wdata};
      end
    end
  end

  // Daisy chain heads, low-true on the wire
  assign dma_grant_out_n = !(st_q.state == S_GRANT);
  assign int_ack_out_n = !int_ack_take;
  assign bus_initialize_oe = !st_q.init_done;
  assign req_ready = (st_q.state == S_IDLE) && !st_q.halted;
  assign rsp = st_q.rsp;
  assign console_debug_mode = st_q.halted;
  assign power_fail_trap = st_q.pfail;
  assign irq_event = st_q.event_pend && !ctl_s.memory_refresh_line;

  // Highest active level wins; refresh masks all requests
  always_comb begin
    irq_level = abc_pkg::LEVEL_NONE;
    if (!ctl_s.memory_refresh_line) begin
      if (ctl_s.int_request_level_four) irq_level = 3'h4;
      if (ctl_s.int_request_level_five) irq_level = 3'h5;
      if (ctl_s.int_request_level_six || st_q.event_pend) irq_level = 3'h6;
      if (ctl_s.int_request_level_seven) irq_level = 3'h7;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_timeout;
    @(posedge clk) disable iff (!rst_n)
    (st_q.state == S_DATA && st_q.tmr == 16'(TIMEOUT_CYCLES - 1) && !ctl_s.slave_reply) |=> rsp.timeout && rsp.done;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not raised");
  property p_grant_idle;
    @(posedge clk) disable iff (!rst_n)
    $fell(dma_grant_out_n) |-> !ctl_oe.cycle_sync && $past(!ctl_s.cycle_sync) && $past(st_q.state == S_IDLE);
  endproperty
  a_grant_idle: assert property (p_grant_idle) else $error("grant while mastering");
  property p_one_master;
    @(posedge clk) disable iff (!rst_n) (st_q.state == S_DMA) |-> (ctl_oe == '0);
  endproperty
  a_one_master: assert property (p_one_master) else $error("driving while DMA owns bus");
  property p_interlock;
    @(posedge clk) disable iff (!rst_n) (ctl_oe.input_strobe && !ctl_s.slave_reply && st_q.tmr < 16'h0005) |=> ctl_oe.cycle_sync;
  endproperty
  a_interlock: assert property (p_interlock) else $error("cycle left without reply");
  property p_refresh_block;
    @(posedge clk) disable iff (!rst_n) ctl_s.memory_refresh_line |-> (irq_level == 3'h0) && !ctl_oe.io_page_select;
  endproperty
  a_refresh_block: assert property (p_refresh_block) else $error("refresh not blocking");
  property p_event;
    @(posedge clk) disable iff (!rst_n)
    (ctl_s.external_event_request && !$past(ctl_s.external_event_request) && !ctl_s.memory_refresh_line) |=>
    (irq_level >= 3'h6);
  endproperty
  a_event: assert property (p_event) else $error("event edge lost");
  property p_pfail;
    @(posedge clk) disable iff (!rst_n) $fell(ctl_s.ac_power_good) && !st_q.halted && st_q.pok_prev |=> power_fail_trap;
  endproperty
  a_pfail: assert property (p_pfail) else $error("power fail missed");
  property p_halt;
    @(posedge clk) disable iff (!rst_n) ctl_s.halt_request_line |=> console_debug_mode && !req_ready;
  endproperty
  a_halt: assert property (p_halt) else $error("halt ignored");
  property p_addr_phase;
    @(posedge clk) disable iff (!rst_n) (st_q.state == S_ADDR) |-> ad_oe == st_q.cur.addr ##1 ctl_oe.cycle_sync;
  endproperty
  a_addr_phase: assert property (p_addr_phase) else $error("address phase wrong");
  c_read: cover property (@(posedge clk) disable iff (!rst_n) rsp.done && !rsp.timeout && !st_q.cur.write);
  c_write: cover property (@(posedge clk) disable iff (!rst_n) rsp.done && st_q.cur.write);
  c_to: cover property (@(posedge clk) disable iff (!rst_n) rsp.timeout);
  c_dma: cover property (@(posedge clk) disable iff (!rst_n) st_q.state == S_DMA);
endmodule

// [test/abc_slave_model.sv]
// Partner model: one-word memory slave and one DMA requester
`timescale 1ns/10ps
module abc_slave_model (
  input wire logic clk,
  input wire logic [17:0] ad_oe,
  input wire abc_pkg::abc_ctl_type ctl_oe,
  input wire abc_pkg::abc_ctl_type sys,
  input wire logic [3:0] dly,
  input wire logic err,
  input wire logic want,
  input wire logic grant_n,
  output logic [17:0] ad_in_n,
  output abc_pkg::abc_ctl_type ctl_in_n
);
  logic [3:0] cnt_q = 4'h0;
  logic rep_q = 1'h0;
  logic sy_q = 1'h0;
  logic own_q = 1'h0;
  logic io_q;
  logic io_p;
  logic wt_p;
  logic wt_q;
  logic bt_q;
  logic [17:0] ad_p;
  logic [17:0] addr_q;
  logic [17:0] drv;
  logic [15:0] mem_q;
  abc_pkg::abc_ctl_type mine;
  ////////////////////////////////////////
  // Slave answers strobes only; delay F never replies
  always @(posedge clk) begin
    sy_q <= ctl_oe.cycle_sync;
    // Address phase ends as sync rises, so latch the copy from the cycle before
    ad_p <= ad_oe;
    io_p <= ctl_oe.io_page_select;
    wt_p <= ctl_oe.write_byte_control;
    if (ctl_oe.cycle_sync && !sy_q) begin
      addr_q <= ad_p;
      io_q <= io_p;
      wt_q <= wt_p;
    end
    if (ctl_oe.input_strobe || ctl_oe.output_strobe) begin
      cnt_q <= cnt_q + 4'h1;
      bt_q <= ctl_oe.write_byte_control;
      rep_q <= (dly != 4'hF) && (cnt_q >= dly);
      if (rep_q && ctl_oe.output_strobe) mem_q <= ad_oe[15:0];
    end else begin
      cnt_q <= 4'h0;
      rep_q <= 1'h0;
    end
    // Keeps a grant only when it asked for one
    if (!want) own_q <= 1'h0;
    else if (!grant_n) own_q <= 1'h1;
  end
  // Data released with the strobe, wire returns to pull-up
  always_comb begin
    drv = '0;
    if (rep_q && ctl_oe.input_strobe) drv = {1'h0, err, mem_q};
    mine = sys;
    mine.slave_reply = rep_q;
    mine.dma_request_line = want && !own_q;
    mine.dma_select_ack = own_q;
  end
  // Open-collector wires: any party pulling low wins
  assign ad_in_n = ~(ad_oe | drv);
  assign ctl_in_n = ~(ctl_oe | mine);
endmodule

// [test/async_backplane_bus_control_bench.sv]
// Self-checking bench for the backplane bus controller
`timescale 1ns/10ps
module async_backplane_bus_control_bench;
  typedef struct packed {
    logic w;
    logic io;
    logic e;
    logic to;
    logic [3:0] dly;
    logic [17:0] a;
    logic [15:0] d;
  } abc_row_type;
  // Flags write/io/error/timeout, reply delay, address, data
  abc_row_type rows [7] = '{{8'h80, 18'h3FFFF, 16'hA55A}, {8'h01, 18'h3FFFF, 16'hA55A},
    {8'h23, 18'h2AAAA, 16'hA55A}, {8'hCC, 18'h01FFF, 16'h1234}, {8'h00, 18'h15555, 16'h1234},
    {8'h1F, 18'h00000, 16'h0000}, {8'h9F, 18'h20000, 16'h0000}};
  logic clk, rst_n, take, want, err, req_ready, grant_n, ack_n, init_oe, evt, dbg, pft;
  logic [3:0] dly;
  logic [2:0] lvl;
  logic [17:0] ad_in_n, ad_out, ad_oe;
  abc_pkg::abc_req_type req;
  abc_pkg::abc_rsp_type rsp;
  abc_pkg::abc_ctl_type ctl_in_n, ctl_oe, sys;
  int err_count = 0;
  int checks_done = 0;
  int n;
  abc_ctrl #(.TIMEOUT_CYCLES(20)) dut (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp),
    .req_ready(req_ready), .ad_in_n(ad_in_n), .ad_out(ad_out), .ad_oe(ad_oe),
    .ctl_in_n(ctl_in_n), .ctl_oe(ctl_oe), .dma_grant_out_n(grant_n), .int_ack_out_n(ack_n),
    .int_ack_take(take), .bus_initialize_oe(init_oe), .irq_level(lvl), .irq_event(evt),
    .console_debug_mode(dbg), .power_fail_trap(pft));
  abc_slave_model m (.clk(clk), .ad_oe(ad_oe), .ctl_oe(ctl_oe), .sys(sys), .dly(dly),
    .err(err), .want(want), .grant_n(grant_n), .ad_in_n(ad_in_n), .ctl_in_n(ctl_in_n));
  ////////////////////////////////////////
  task chk(input logic [17:0] got, input logic [17:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wt(input int c);
    repeat (c) @(negedge clk);
  endtask
  task results;
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Wait for done, bounded
  task wait_done;
    n = 0;
    while (rsp.done !== 1'h1 && n < 100) begin
      if (want) chk(grant_n, 1'h1);
      wt(1);
      n++;
    end
  endtask
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    results;
  end
  initial begin
    rst_n = 1'h0;
    take = 1'h0;
    want = 1'h0;
    err = 1'h0;
    dly = 4'h0;
    req = '0;
    sys = '0;
    sys.ac_power_good = 1'h1;
    sys.dc_power_good = 1'h1;
    wt(20);
    chk(init_oe, 1'h1);
    chk(ctl_oe, '0);
    chk(ad_oe, '0);
    chk(grant_n, 1'h1);
    chk(ad_out, '0);
    rst_n = 1'h1;
    wt(3);
    chk(init_oe, 1'h0);
    // Ordinary transfers, prompt, slow and unanswered
    foreach (rows[i]) begin
      dly = rows[i].dly;
      err = rows[i].e;
      // I/O page rows also run as byte cycles
      req = '{1'h1, rows[i].w, rows[i].io, rows[i].io, rows[i].a, rows[i].d};
      wt(1);
      req.valid = 1'h0;
      wait_done;
      chk(rsp.done, 1'h1);
      chk(rsp.timeout, rows[i].to);
      chk(rows[i].to && n < 20, 1'h0);
      chk(rsp.mem_error, rows[i].e);
      chk(m.addr_q, rows[i].a);
      chk(m.io_q, rows[i].io);
      chk(m.wt_q, rows[i].w);
      chk(m.bt_q, rows[i].w && rows[i].io);
      if (!rows[i].w && !rows[i].to) chk(rsp.rdata, rows[i].d);
      wt(1);
    end
    // DMA request arrives mid-cycle; grant must wait for the end
    dly = 4'h8;
    req = '{1'h1, 1'h0, 1'h0, 1'h0, 18'h00010, 16'h0000};
    wt(1);
    req.valid = 1'h0;
    want = 1'h1;
    wait_done;
    n = 0;
    while (grant_n !== 1'h0 && n < 20) begin
      wt(1);
      n++;
    end
    chk(grant_n, 1'h0);
    wt(4);
    chk(req_ready, 1'h0);
    chk(ctl_oe.cycle_sync, 1'h0);
    want = 1'h0;
    wt(6);
    chk(grant_n, 1'h1);
    chk(req_ready, 1'h1);
    // Interrupt levels, then refresh masks them
    sys.int_request_level_five = 1'h1;
    wt(4);
    chk(lvl, 3'h5);
    sys.int_request_level_seven = 1'h1;
    wt(4);
    chk(lvl, 3'h7);
    sys.memory_refresh_line = 1'h1;
    wt(4);
    chk(lvl, 3'h0);
    sys.int_request_level_five = 1'h0;
    sys.int_request_level_seven = 1'h0;
    sys.memory_refresh_line = 1'h0;
    // Event edge latched at level six until taken
    sys.external_event_request = 1'h1;
    wt(4);
    sys.external_event_request = 1'h0;
    chk(evt, 1'h1);
    chk(lvl, 3'h6);
    take = 1'h1;
    #1 chk(ack_n, 1'h0);
    wt(1);
    take = 1'h0;
    wt(2);
    chk(evt, 1'h0);
    chk(ack_n, 1'h1);
    // Power loss while running, then halt
    sys.ac_power_good = 1'h0;
    wt(4);
    chk(pft, 1'h1);
    sys.halt_request_line = 1'h1;
    wt(4);
    chk(dbg, 1'h1);
    chk(req_ready, 1'h0);
    results;
  end
endmodule
